// *** verif/tb.sv ***
// Bench for the register bank.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cal_test_mode = 1'b0;
   logic adc_enable = 1'b0;
   logic adc_clk_disable = 1'b0;
   logic [5:0] src = 6'h00;
   logic [7:0] adc_raw = 8'h10;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n, adc_clk, test_mux_out;
   logic [7:0] vco_band, adc_corrected, q;
   logic [3:0] vco_core_onehot, vco_bias_code, tune_target_code, c, b;
   logic [2:0] m;
   int x, num_errors = 0, checked = 0;
   logic [7:0] dflt [7] = '{8'h4C, 8'h30, 8'h00, 8'h00, 8'h07, 8'h55, 8'h00};
   logic [7:0] auto_band = 8'hA5;
   logic [3:0] auto_core = 4'h3;
   logic [3:0] auto_bias = 4'hC;
   logic [3:0] auto_tune = 4'h9;
   // Undriven line shows the inverse, so a missing output enable is caught
   wire sdo_line = spi_sdo_oe_n ? ~spi_sdo : spi_sdo;
   always #20 sys_clk = ~sys_clk;
   vcrb_host host (.sys_clk, .sclk(spi_sclk), .cs_n(spi_cs_n), .sdi(spi_sdi), .sdo(sdo_line));
   vcrb_bank uut (.sys_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
      .cal_test_mode, .adc_enable, .adc_clk_disable, .auto_band, .auto_core_onehot(auto_core),
      .auto_bias_code(auto_bias), .auto_tune_code(auto_tune), .adc_raw, .cal_busy(src[0]), .n_band(src[1]),
      .r_band(src[2]), .timeout_clk(src[3]), .bias_min(src[4]), .adc_busy(src[5]), .adc_clk,
      .vco_band, .vco_core_onehot, .vco_bias_code, .tune_target_code, .adc_corrected, .test_mux_out);
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      host.frame({9'h100, a, 8'h00}, q);
      cmp("reg", e, q);
   endtask
   task automatic defaults;
      for (int i = 0; i < 7; i++) rd(7'h35 + 7'(i), dflt[i]);
   endtask
   task automatic lvl(input logic v);
      x = 0;
      while (adc_clk !== v && x < 300) begin
         @(negedge sys_clk);
         x++;
      end
   endtask
   task automatic conclude;
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      conclude;
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      defaults;
      for (int i = 0; i < 7; i++) host.frame({9'h000, 7'h35 + 7'(i), 8'hFF}, q);
      for (int i = 0; i < 7; i++) rd(7'h35 + 7'(i), i == 6 ? 8'h00 : i == 4 ? 8'h7F : 8'hFF);
      cmp("corr", 8'(8'h10 + 8'hFF - 8'h55), adc_corrected);
      cal_test_mode <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         c = i == 0 ? 4'h0 : 4'(1 << (i - 1));
         b = 4'(i * 15 / 4);
         host.frame({9'h000, 7'h38, c, b}, q);
         cmp("core", {4'h0, c}, {4'h0, vco_core_onehot});
         cmp("bias", {4'h0, b}, {4'h0, vco_bias_code});
      end
      cmp("band", 8'hFF, vco_band);
      for (int k = 0; k < 16; k++) begin
         m = 3'(k);
         x = m < 3 ? m : m - 1;
         host.frame({9'h000, 7'h39, 1'b0, m, 4'(k)}, q);
         src <= m == 3 || m == 7 ? 6'h3F : 6'h01 << x;
         adc_raw <= 8'(k * 17);
         auto_band <= ~8'(k);
         auto_tune <= ~4'(k);
         repeat (3) @(posedge sys_clk);
         cmp("tune", 8'(k), {4'h0, tune_target_code});
         cmp("mux", {7'h00, m != 3 && m != 7}, {7'h00, test_mux_out});
         src <= ~src;
         repeat (3) @(posedge sys_clk);
         cmp("mux", 8'h00, {7'h00, test_mux_out});
      end
      cal_test_mode <= 1'b0;
      repeat (3) @(posedge sys_clk);
      cmp("band", auto_band, vco_band);
      cmp("core", {4'h0, auto_core}, {4'h0, vco_core_onehot});
      cmp("bias", {4'h0, auto_bias}, {4'h0, vco_bias_code});
      cmp("tune", {4'h0, auto_tune}, {4'h0, tune_target_code});
      host.frame({9'h000, 7'h35, 8'h3E}, q);
      adc_enable <= 1'b1;
      adc_clk_disable <= 1'b1;
      repeat (30) @(posedge sys_clk);
      lvl(1'b0);
      lvl(1'b1);
      lvl(1'b0);
      cmp("adc", 8'((4 * 62 + 2) / 2), 8'(x));
      adc_enable <= 1'b0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      defaults;
      conclude;
   end
endmodule

// *** verif/vcrb_bank_chk.sv ***
// Checker on the bank's ports.
// Assumes one clock domain.
`timescale 1ns/1ps
module vcrb_bank_chk (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spi_cs_n,
   input wire logic spi_sdo_oe_n,
   input wire logic cal_test_mode,
   input wire logic adc_enable,
   input wire logic [7:0] auto_band,
   input wire logic [3:0] auto_core_onehot,
   input wire logic [3:0] auto_tune_code,
   input wire logic [7:0] adc_raw,
   input wire logic adc_clk,
   input wire logic [7:0] vco_band,
   input wire logic [3:0] vco_core_onehot,
   input wire logic [3:0] tune_target_code,
   input wire logic [7:0] adc_corrected
);
   logic [2:0] up = 3'h0;
   // Checks wait until two-deep history no longer reaches into reset
   always_ff @(posedge sys_clk) up <= reset_n ? {up[1:0], 1'b1} : 3'h0;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!up[2]);
   sequence quiet;
      spi_cs_n && $past(spi_cs_n, 6);
   endsequence
   a_auto_band: assert property (!$past(cal_test_mode) |-> vco_band == $past(auto_band))
      else $error("band");
   a_auto_core: assert property (!$past(cal_test_mode) |-> vco_core_onehot == $past(auto_core_onehot))
      else $error("core");
   a_auto_tune: assert property (!$past(cal_test_mode) |-> tune_target_code == $past(auto_tune_code))
      else $error("tune");
   a_forced_hold: assert property ($past(cal_test_mode, 2) && $past(cal_test_mode) ##0 quiet
      |-> $stable({vco_band, tune_target_code})) else $error("forced");
   a_adc_sum: assert property (quiet |-> 8'(adc_corrected - $past(adc_corrected))
      == 8'($past(adc_raw) - $past(adc_raw, 2))) else $error("offset");
   a_adc_stop: assert property (!$past(adc_enable) && !$past(adc_enable, 2) |-> $stable(adc_clk))
      else $error("adc clk");
   a_sdo_idle: assert property (quiet |-> spi_sdo_oe_n)
      else $error("sdo idle");
   a_sdo_frame: assert property (!spi_sdo_oe_n |-> !$past(spi_cs_n, 5))
      else $error("sdo frame");
endmodule
bind vcrb_bank vcrb_bank_chk chk (.sys_clk, .reset_n, .spi_cs_n, .spi_sdo_oe_n, .cal_test_mode, .adc_enable,
   .auto_band, .auto_core_onehot, .auto_tune_code, .adc_raw, .adc_clk, .vco_band, .vco_core_onehot,
   .tune_target_code, .adc_corrected);

// *** verif/vcrb_host.sv ***
// Host model for the bank's three-wire serial port.
// Assumes sys_clk paces frames; half sclk period is five clocks.
`timescale 1ns/1ps
module vcrb_host (
   input wire logic sys_clk,
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   task automatic frame(input logic [23:0] f, output logic [7:0] q);
      cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         repeat (5) @(posedge sys_clk);
         sclk <= 1'b0;
         sdi <= f[i];
         repeat (5) @(posedge sys_clk);
         sclk <= 1'b1;
         if (i < 8) q[i] = sdo;
      end
      repeat (5) @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (5) @(posedge sys_clk);
      cs_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule

// *** verilog/vcrb_bank.sv ***
// VCO calibration register bank with three-wire serial access, ADC clock divider,
// test-mode overrides and test multiplexer.
// Assumes sys_clk is the phase-detector-derived clock; serial pins are asynchronous to it.
`timescale 1ns/1ps
`include "vcrb_params.svh"

// Functional notes
// R1: ADC clock is fpd / (4*div+2)
// R2: Host targets roughly 100 kHz ADC clock
// R3: Test mode forces the VCO band value
// R4: Forced core field is one-hot, zero all off
// R5: Forced bias code zero maximum, fifteen minimum
// R6: Test mux routes six internal calibration signals
// R7: Tune target code picks sixteen linear voltages
// R8: ADC offset corrects calibration ADC results
// R9: ADC enable overrides ADC clock disable
// R10: Outside test mode overrides have no effect
// R11: Reserved bits read zero; reset restores defaults (the reserved 0x36 register reads back what was written)
module vcrb_bank (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic cal_test_mode,
   input wire logic adc_enable,
   input wire logic adc_clk_disable,
   input wire logic [7:0] auto_band,
   input wire logic [3:0] auto_core_onehot,
   input wire logic [3:0] auto_bias_code,
   input wire logic [3:0] auto_tune_code,
   input wire logic [7:0] adc_raw,
   input wire logic cal_busy,
   input wire logic n_band,
   input wire logic r_band,
   input wire logic timeout_clk,
   input wire logic bias_min,
   input wire logic adc_busy,
   output logic adc_clk,
   output logic [7:0] vco_band,
   output logic [3:0] vco_core_onehot,
   output logic [3:0] vco_bias_code,
   output logic [3:0] tune_target_code,
   output logic [7:0] adc_corrected,
   output logic test_mux_out
);
   logic [7:0] adc_clock_divide;
   logic [7:0] charge_pump_trim_reserved;
   logic [7:0] forced_band;
   logic [7:0] forced_core_and_bias;
   logic [7:0] test_mux_and_tune_target;
   logic [7:0] cal_adc_offset;

   // Two-stage synchronisers for the serial pins
   logic [1:0] sclk_s;
   logic [1:0] cs_s;
   logic [1:0] sdi_s;
   logic sclk_d;
   logic [4:0] bit_cnt;
   logic frame_read;
   logic [23:0] shift_in;
   logic [7:0] shift_out;
   logic [7:0] rd_data;

   // Chip select resets idle and sclk low, so no false edge follows reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclk_s <= 2'h0;
         cs_s <= 2'h3;
         sdi_s <= 2'h0;
         sclk_d <= 1'b0;
      end else begin
         sclk_s <= {sclk_s[0], spi_sclk};
         cs_s <= {cs_s[0], spi_cs_n};
         sdi_s <= {sdi_s[0], spi_sdi};
         sclk_d <= sclk_s[1];
      end
   end

   wire sclk_rise = sclk_s[1] & ~sclk_d;
   wire sclk_fall = ~sclk_s[1] & sclk_d;
   wire cs_active = ~cs_s[1];
   wire [23:0] next_shift_in = {shift_in[22:0], sdi_s[1]};
   // Frame: R/W bit, 15 address bits, 8 data bits; the bank decodes the low 7 address bits
   // Upper address bits are ignored, so the bank aliases every 128 addresses
   wire addr_phase_done = sclk_rise && (bit_cnt == 5'h0F);
   wire write_strobe = sclk_rise && (bit_cnt == 5'(`VCRB_FRAME_BITS - 1)) && !next_shift_in[23];
   wire [6:0] wr_addr = next_shift_in[14:8];
   wire [7:0] wr_data = next_shift_in[7:0];
   wire [6:0] rd_addr = next_shift_in[6:0];

   // Unmapped addresses read as zero; the reserved 0x36 register reads back what was written
   assign rd_data = (rd_addr == `VCRB_ADDR_ADC_CLK_DIV) ? adc_clock_divide :
                    (rd_addr == `VCRB_ADDR_PUMP_TRIM) ? charge_pump_trim_reserved :
                    (rd_addr == `VCRB_ADDR_FORCED_BAND) ? forced_band :
                    (rd_addr == `VCRB_ADDR_CORE_BIAS) ? forced_core_and_bias :
                    (rd_addr == `VCRB_ADDR_MUX_TUNE) ? test_mux_and_tune_target :
                    (rd_addr == `VCRB_ADDR_ADC_OFFSET) ? cal_adc_offset : 8'h00;

   // Direction is latched at the 16th rise: the R/W bit leaves the
   // observed part of the shifter as soon as data bits follow it
   // Read data is launched on falls so it is settled at the host's rise
   // Raising chip select mid-frame discards the partial frame
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !cs_active) begin
         bit_cnt <= 5'h00;
         shift_in <= 24'h000000;
         shift_out <= 8'h00;
         frame_read <= 1'b0;
         spi_sdo <= 1'b0;
         spi_sdo_oe_n <= 1'b1;
      end else begin
         if (sclk_rise) begin
            shift_in <= next_shift_in;
            bit_cnt <= (bit_cnt == 5'(`VCRB_FRAME_BITS - 1)) ? 5'h00 : bit_cnt + 5'h01;
            if (addr_phase_done) begin
               frame_read <= next_shift_in[15];
            end
            if (addr_phase_done && next_shift_in[15]) begin
               shift_out <= rd_data;
            end
         end
         if (sclk_fall && frame_read && (bit_cnt >= 5'h10)) begin
            spi_sdo <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
            spi_sdo_oe_n <= 1'b0;
         end
      end
   end

   // Writes commit at the 24th rise; read frames never disturb the bank
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         adc_clock_divide <= `VCRB_RST_ADC_CLK_DIV; // R11
         charge_pump_trim_reserved <= `VCRB_RST_PUMP_TRIM;
         forced_band <= `VCRB_RST_FORCED_BAND;
         forced_core_and_bias <= `VCRB_RST_CORE_BIAS;
         test_mux_and_tune_target <= `VCRB_RST_MUX_TUNE;
         cal_adc_offset <= `VCRB_RST_ADC_OFFSET;
      end else if (write_strobe) begin
         case (wr_addr)
            `VCRB_ADDR_ADC_CLK_DIV: adc_clock_divide <= wr_data;
            `VCRB_ADDR_PUMP_TRIM: charge_pump_trim_reserved <= wr_data;
            `VCRB_ADDR_FORCED_BAND: forced_band <= wr_data;
            `VCRB_ADDR_CORE_BIAS: forced_core_and_bias <= wr_data;
            `VCRB_ADDR_MUX_TUNE: test_mux_and_tune_target <= wr_data & `VCRB_MUX_TUNE_MASK; // R11
            `VCRB_ADDR_ADC_OFFSET: cal_adc_offset <= wr_data;
            default: ;
         endcase
      end
   end

   // ADC clock: half period of 2*div+1 cycles gives fpd/(4*div+2)
   // A new divide applies to the half period in progress; a smaller one wraps at once
   // because the compare is greater-or-equal, so the count never runs away
   logic [9:0] div_cnt;
   wire [9:0] div_period = 10'(`VCRB_DIV_MUL) * {2'h0, adc_clock_divide} + 10'(`VCRB_DIV_ADD); // R1
   wire [9:0] half_period = {1'b0, div_period[9:1]};
   wire adc_clk_run = adc_enable; // R9
   wire div_wrap = (div_cnt >= half_period - 10'h001);

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !adc_clk_run) begin
         div_cnt <= 10'h000;
         adc_clk <= 1'b0;
      end else if (div_wrap) begin
         div_cnt <= 10'h000;
         adc_clk <= ~adc_clk; // R1
      end else begin
         div_cnt <= div_cnt + 10'h001;
      end
   end

   // Overrides pass only in test mode
   wire [7:0] next_band = cal_test_mode ? forced_band : auto_band; // R3 R10
   wire [3:0] next_core = cal_test_mode ? forced_core_and_bias[`VCRB_CORE_MSB:`VCRB_CORE_LSB]
                                        : auto_core_onehot; // R4 R10
   wire [3:0] next_bias = cal_test_mode ? forced_core_and_bias[`VCRB_BIAS_MSB:`VCRB_BIAS_LSB]
                                        : auto_bias_code; // R5 R10
   wire [3:0] next_tune = cal_test_mode ? test_mux_and_tune_target[`VCRB_TUNE_MSB:`VCRB_TUNE_LSB]
                                        : auto_tune_code; // R7 R10
   // Offset 0x55, the reset value, is neutral; correction is modulo 256
   wire [7:0] next_adc = 8'(adc_raw + cal_adc_offset - `VCRB_RST_ADC_OFFSET); // R8

   vcrb_pkg::vcrb_mux_t mux_sel;
   assign mux_sel = vcrb_pkg::vcrb_mux_t'(test_mux_and_tune_target[`VCRB_MUX_MSB:`VCRB_MUX_LSB]);
   logic next_mux;
   // Reserved code and the low code both give a quiet zero
   always_comb begin
      case (mux_sel) // R6
         vcrb_pkg::VCRB_MUX_CAL_BUSY: next_mux = cal_busy;
         vcrb_pkg::VCRB_MUX_N_BAND: next_mux = n_band;
         vcrb_pkg::VCRB_MUX_R_BAND: next_mux = r_band;
         vcrb_pkg::VCRB_MUX_TIMEOUT_CLK: next_mux = timeout_clk;
         vcrb_pkg::VCRB_MUX_BIAS_MIN: next_mux = bias_min;
         vcrb_pkg::VCRB_MUX_ADC_BUSY: next_mux = adc_busy;
         default: next_mux = 1'b0;
      endcase
   end

   // Registered so every output leaves straight from a flip-flop
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         vco_band <= 8'h00;
         vco_core_onehot <= 4'h0;
         vco_bias_code <= 4'h0;
         tune_target_code <= 4'h0;
         adc_corrected <= 8'h00;
         test_mux_out <= 1'b0;
      end else begin
         vco_band <= next_band;
         vco_core_onehot <= next_core;
         vco_bias_code <= next_bias;
         tune_target_code <= next_tune;
         adc_corrected <= next_adc;
         test_mux_out <= next_mux;
      end
   end

   // adc_clk_disable is overridden by adc_enable and so never gates the clock
   wire unused_ok = adc_clk_disable;
endmodule

// *** verilog/vcrb_params.svh ***
// Register offsets, field positions and reset values of the VCO calibration register bank.
// Included by the bank; definitions only.
`ifndef VCRB_PARAMS_SVH
`define VCRB_PARAMS_SVH
`define VCRB_ADDR_ADC_CLK_DIV 7'h35
`define VCRB_ADDR_PUMP_TRIM 7'h36
`define VCRB_ADDR_FORCED_BAND 7'h37
`define VCRB_ADDR_CORE_BIAS 7'h38
`define VCRB_ADDR_MUX_TUNE 7'h39
`define VCRB_ADDR_ADC_OFFSET 7'h3A
`define VCRB_RST_ADC_CLK_DIV 8'h4C
`define VCRB_RST_PUMP_TRIM 8'h30
`define VCRB_RST_FORCED_BAND 8'h00
`define VCRB_RST_CORE_BIAS 8'h00
`define VCRB_RST_MUX_TUNE 8'h07
`define VCRB_RST_ADC_OFFSET 8'h55
`define VCRB_MUX_TUNE_MASK 8'h7F
`define VCRB_CORE_MSB 7
`define VCRB_CORE_LSB 4
`define VCRB_BIAS_MSB 3
`define VCRB_BIAS_LSB 0
`define VCRB_MUX_MSB 6
`define VCRB_MUX_LSB 4
`define VCRB_TUNE_MSB 3
`define VCRB_TUNE_LSB 0
`define VCRB_DIV_MUL 4
`define VCRB_DIV_ADD 2
`define VCRB_FRAME_BITS 24
`endif

// *** verilog/vcrb_pkg.sv ***
// Types shared by the VCO calibration register bank.
// Assumes nothing of its surroundings.
package vcrb_pkg;
   typedef enum logic [2:0] {
      VCRB_MUX_CAL_BUSY,
      VCRB_MUX_N_BAND,
      VCRB_MUX_R_BAND,
      VCRB_MUX_RESERVED,
      VCRB_MUX_TIMEOUT_CLK,
      VCRB_MUX_BIAS_MIN,
      VCRB_MUX_ADC_BUSY,
      VCRB_MUX_LOW
   } vcrb_mux_t;
endpackage
